// file: hw/evstk_core.sv
// evstk_core.sv - integer and floating-point evaluation stack datapath
// Operation
// RULE_01 - integer stack has top, second, third
// RULE_02 - load pushes second to third, top down
// RULE_03 - store pops second up, third up
// RULE_04 - third keeps old value after pop
// RULE_05 - float stack three deep, same push/pop
// RULE_06 - add sums top two into top
// RULE_07 - float addresses come from integer stack
// RULE_08 - 32-bit integer, 64-bit IEEE float
// RULE_09 - flat 32-bit linear addresses
// RULE_10 - byte and half-word operations supported
// RULE_11 - instruction pointer advances per instruction
// RULE_12 - workspace pointer for locals and calls; here it is only loaded from top by SWP and never used to form an address
// RULE_13 - operand register builds operands
// RULE_14 - protected accesses checked and translated
// RULE_15 - protected mode blocks privileged instructions
// RULE_16 - errors trapped per process and globally
`include "evstk_map.svh"
`default_nettype none
module evstk_core #(
  parameter int IW = `EVSTK_IW,
  parameter int FW = `EVSTK_FW
) (
  // clock and reset
  input  wire logic                 CLK_SYS_IN,
  input  wire logic                 RST_N_IN,
  // instruction stream
  input  wire evstk_pkg::evstk_cmd_t CMD_IN,
  // protection and error control
  input  wire logic                 PROT_IN,
  input  wire logic [31:0]          MMU_BASE_IN,
  input  wire logic [31:0]          MMU_LIMIT_IN,
  input  wire logic                 TRAP_EN_IN,
  input  wire logic                 ERR_CLR_IN,
  // stack contents
  output logic      [31:0]          TOP_OUT,
  output logic      [31:0]          SEC_OUT,
  output logic      [31:0]          THD_OUT,
  output logic      [63:0]          FTOP_OUT,
  output logic      [63:0]          FSEC_OUT,
  output logic      [63:0]          FTHD_OUT,
  // pointers
  output logic      [31:0]          IPTR_OUT,
  output logic      [31:0]          WPTR_OUT,
  output logic      [31:0]          OPND_OUT,
  // memory request
  output logic                      MEM_VLD_OUT,
  output logic                      MEM_WR_OUT,
  output logic      [31:0]          MEM_ADDR_OUT,
  output logic      [63:0]          MEM_WDATA_OUT,
  // errors
  output logic                      TRAP_OUT,
  output logic                      PROC_ERR_OUT,
  output logic                      GLOB_ERR_OUT
);
  if (IW != 32 || FW != 64) begin : g_width_chk
    $error("evstk_core needs 32/64-bit units"); // [RULE_08]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  evstk_pkg::evstk_op_t op;        // current opcode
  logic                 is_push;   // integer load
  logic                 is_pop;    // integer store, float address use or SWP
  logic                 need_addr; // memory access
  logic                 priv;      // privileged class
  logic [31:0]          addr_raw;  // untranslated address
  logic [31:0]          phys;      // translated address
  logic                 mmu_fault; // out of protected range
  logic                 fault;     // instruction traps
  logic                 go;        // instruction executes
  logic [31:0]          ld_val;    // value pushed on integer stack
  logic [63:0]          f_val;     // value pushed on float stack
  logic [31:0]          top_q;     // integer top entry, also float address
  logic [31:0]          opnd_q;    // operand being built

  always_comb begin
    op        = CMD_IN.op;
    is_push   = (op == evstk_pkg::EVSTK_LDC) || (op == evstk_pkg::EVSTK_LDB) ||
                (op == evstk_pkg::EVSTK_LDH);
    is_pop    = (op == evstk_pkg::EVSTK_ST) || (op == evstk_pkg::EVSTK_STB) ||
                (op == evstk_pkg::EVSTK_STH) || (op == evstk_pkg::EVSTK_FLD) ||
                (op == evstk_pkg::EVSTK_FST) || (op == evstk_pkg::EVSTK_SWP);
    need_addr = is_pop && (op != evstk_pkg::EVSTK_SWP);
    priv      = (op == evstk_pkg::EVSTK_SWP);
    // float addresses are formed on the integer stack
    if (op == evstk_pkg::EVSTK_FLD || op == evstk_pkg::EVSTK_FST) begin
      addr_raw = top_q; // [RULE_07]
    end else begin
      addr_raw = opnd_q;
    end
    fault = CMD_IN.vld && ((PROT_IN && priv) || (need_addr && mmu_fault)); // [RULE_15]
    go    = CMD_IN.vld && !fault;
    // narrow loads zero-extend
    if (op == evstk_pkg::EVSTK_LDB) begin
      ld_val = CMD_IN.data & `EVSTK_BYTE_MSK; // [RULE_10]
    end else if (op == evstk_pkg::EVSTK_LDH) begin
      ld_val = CMD_IN.data & `EVSTK_HALF_MSK; // [RULE_10]
    end else begin
      ld_val = CMD_IN.data;
    end
    // single precision lives in the low word
    f_val = CMD_IN.dbl ? CMD_IN.fdata : (CMD_IN.fdata & `EVSTK_SGL_MSK); // [RULE_08]
  end

  // check unit sits on every memory address
  evstk_addr_chk #(
    .AW (32)
  ) u_chk (
    .prot_in   ({31'h0000_0000, PROT_IN}),
    .addr_in   (addr_raw),
    .base_in   (MMU_BASE_IN),
    .limit_in  (MMU_LIMIT_IN),
    .phys_out  (phys),
    .fault_out (mmu_fault)
  ); // [RULE_14]

  ////////////////////////////////////////////////////////////////////////////////
  // integer stack
  logic [31:0] sec_q; // second entry
  logic [31:0] thd_q; // third entry

  // push, pop and add; third is left alone on pop
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      top_q <= `EVSTK_RST_WORD;
      sec_q <= `EVSTK_RST_WORD;
      thd_q <= `EVSTK_RST_WORD;
    end else if (go) begin
      if (is_push) begin
        thd_q <= sec_q; // [RULE_02]
        sec_q <= top_q; // [RULE_02]
        top_q <= ld_val; // [RULE_01]
      end else if (is_pop) begin
        top_q <= sec_q; // [RULE_03]
        sec_q <= thd_q; // [RULE_03] [RULE_04]
      end else if (op == evstk_pkg::EVSTK_ADD) begin
        top_q <= top_q + sec_q; // [RULE_06]
        sec_q <= thd_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // float stack
  logic [63:0] ftop_q; // float top
  logic [63:0] fsec_q; // float second
  logic [63:0] fthd_q; // float third

  // same push/pop order as the integer stack
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ftop_q <= `EVSTK_RST_FWORD;
      fsec_q <= `EVSTK_RST_FWORD;
      fthd_q <= `EVSTK_RST_FWORD;
    end else if (go && op == evstk_pkg::EVSTK_FLD) begin
      fthd_q <= fsec_q; // [RULE_05]
      fsec_q <= ftop_q; // [RULE_05]
      ftop_q <= f_val;
    end else if (go && op == evstk_pkg::EVSTK_FST) begin
      ftop_q <= fsec_q; // [RULE_05]
      fsec_q <= fthd_q; // [RULE_05]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pointers
  logic [31:0] iptr_q; // next instruction address
  logic [31:0] wptr_q; // workspace base

  // a trapped instruction does not advance, so it can be restarted
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      iptr_q <= `EVSTK_RST_WORD;
    end else if (go) begin
      iptr_q <= iptr_q + `EVSTK_IP_STEP; // [RULE_11] [RULE_09]
    end
  end

  // workspace moves only by the privileged set
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      wptr_q <= `EVSTK_RST_WORD;
    end else if (go && op == evstk_pkg::EVSTK_SWP) begin
      wptr_q <= top_q; // [RULE_12]
    end
  end

  // prefix shifts in a nibble; any other executed op except a no-op consumes it
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      opnd_q <= `EVSTK_RST_WORD;
    end else if (go && op == evstk_pkg::EVSTK_PFX) begin
      opnd_q <= (opnd_q | {28'h000_0000, CMD_IN.data[3:0]}) << `EVSTK_NIB_SH; // [RULE_13]
    end else if (go && op != evstk_pkg::EVSTK_NOP) begin
      opnd_q <= `EVSTK_RST_WORD; // [RULE_13]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // memory request
  logic        mvld_q;  // request strobe
  logic        mwr_q;   // write request
  logic [31:0] maddr_q; // physical address
  logic [63:0] mwd_q;   // write data

  // one-cycle request after each executed memory op
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mvld_q  <= 1'b0;
      mwr_q   <= 1'b0;
      maddr_q <= `EVSTK_RST_WORD;
      mwd_q   <= `EVSTK_RST_FWORD;
    end else begin
      mvld_q <= go && need_addr; // [RULE_14]
      mwr_q  <= go && need_addr && (op != evstk_pkg::EVSTK_FLD);
      if (go && need_addr) begin
        maddr_q <= phys; // [RULE_09] [RULE_14]
        if (op == evstk_pkg::EVSTK_FST) begin
          mwd_q <= ftop_q; // [RULE_07]
        end else if (op == evstk_pkg::EVSTK_STB) begin
          mwd_q <= {32'h0000_0000, top_q & `EVSTK_BYTE_MSK}; // [RULE_10]
        end else if (op == evstk_pkg::EVSTK_STH) begin
          mwd_q <= {32'h0000_0000, top_q & `EVSTK_HALF_MSK}; // [RULE_10]
        end else begin
          mwd_q <= {32'h0000_0000, top_q};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // errors
  logic trap_q; // trap pulse
  logic perr_q; // per-process error flag
  logic gerr_q; // global error flag

  // set beats clear so a trap in the clearing cycle is kept
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      trap_q <= 1'b0;
      perr_q <= 1'b0;
      gerr_q <= 1'b0;
    end else begin
      trap_q <= fault;
      perr_q <= (fault && TRAP_EN_IN) || (perr_q && !ERR_CLR_IN); // [RULE_16]
      gerr_q <= (fault && !TRAP_EN_IN) || (gerr_q && !ERR_CLR_IN); // [RULE_16]
    end
  end

  // outputs straight from flops
  assign TOP_OUT       = top_q;
  assign SEC_OUT       = sec_q;
  assign THD_OUT       = thd_q;
  assign FTOP_OUT      = ftop_q;
  assign FSEC_OUT      = fsec_q;
  assign FTHD_OUT      = fthd_q;
  assign IPTR_OUT      = iptr_q;
  assign WPTR_OUT      = wptr_q;
  assign OPND_OUT      = opnd_q;
  assign MEM_VLD_OUT   = mvld_q;
  assign MEM_WR_OUT    = mwr_q;
  assign MEM_ADDR_OUT  = maddr_q;
  assign MEM_WDATA_OUT = mwd_q;
  assign TRAP_OUT      = trap_q;
  assign PROC_ERR_OUT  = perr_q;
  assign GLOB_ERR_OUT  = gerr_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);

  chk_push_order: assert property (go && is_push |=> // [RULE_02]
    top_q == $past(ld_val) && sec_q == $past(top_q) && thd_q == $past(sec_q))
    else $error("push order wrong");
  chk_pop_order: assert property (go && is_pop |=> // [RULE_03]
    top_q == $past(sec_q) && sec_q == $past(thd_q))
    else $error("pop order wrong");
  chk_pop_third: assert property (go && is_pop |=> $stable(thd_q)) // [RULE_04]
    else $error("third changed on pop");
  chk_add_sum: assert property (go && op == evstk_pkg::EVSTK_ADD |=> // [RULE_06]
    top_q == $past(top_q) + $past(sec_q))
    else $error("add result wrong");
  chk_fp_push: assert property (go && op == evstk_pkg::EVSTK_FLD |=> // [RULE_05]
    fsec_q == $past(ftop_q) && fthd_q == $past(fsec_q))
    else $error("float push wrong");
  chk_ip_hold: assert property (fault |=> $stable(iptr_q)) // [RULE_11]
    else $error("ip moved on trap");
  chk_priv_block: assert property (CMD_IN.vld && PROT_IN && priv |=> // [RULE_15]
    trap_q && $stable(wptr_q))
    else $error("privileged op ran");
  chk_mmu_fault: assert property (CMD_IN.vld && PROT_IN && need_addr && // [RULE_14]
    addr_raw > MMU_LIMIT_IN |=> !mvld_q && trap_q)
    else $error("range fault missed");
  chk_err_sticky: assert property (trap_q && $past(TRAP_EN_IN) |-> perr_q) // [RULE_16]
    else $error("process error lost");
  chk_byte_load: assert property (go && op == evstk_pkg::EVSTK_LDB |=> // [RULE_10]
    top_q[31:8] == 24'h00_0000)
    else $error("byte load not masked");

  cov_add:  cover property (go && op == evstk_pkg::EVSTK_ADD);
  cov_fst:  cover property (go && op == evstk_pkg::EVSTK_FST);
  cov_trap: cover property (fault && ERR_CLR_IN);
endmodule
`default_nettype wire

// file: hw/evstk_map.svh
// evstk_map.svh - masks, widths, reset values and step counts of the stack datapath
`ifndef EVSTK_MAP_SVH
`define EVSTK_MAP_SVH
`define EVSTK_IW        32
`define EVSTK_FW        64
`define EVSTK_RST_WORD  32'h0000_0000
`define EVSTK_RST_FWORD 64'h0000_0000_0000_0000
`define EVSTK_IP_STEP   32'h0000_0001
`define EVSTK_BYTE_MSK  32'h0000_00FF
`define EVSTK_HALF_MSK  32'h0000_FFFF
`define EVSTK_SGL_MSK   64'h0000_0000_FFFF_FFFF
`define EVSTK_NIB_SH    4
`endif

// file: hw/evstk_pkg.sv
// evstk_pkg.sv - types shared by the stack datapath files
`default_nettype none
package evstk_pkg;
  // instruction classes seen by the datapath
  typedef enum logic [3:0] {
    EVSTK_NOP = 4'h0,
    EVSTK_LDC = 4'h1,
    EVSTK_LDB = 4'h2,
    EVSTK_LDH = 4'h3,
    EVSTK_ST  = 4'h4,
    EVSTK_STB = 4'h5,
    EVSTK_STH = 4'h6,
    EVSTK_ADD = 4'h7,
    EVSTK_PFX = 4'h8,
    EVSTK_FLD = 4'h9,
    EVSTK_FST = 4'hA,
    EVSTK_SWP = 4'hB
  } evstk_op_t;

  // one instruction with its memory data
  typedef struct packed {
    logic             vld;
    evstk_op_t        op;
    logic             dbl;
    logic [31:0]      data;
    logic [63:0]      fdata;
  } evstk_cmd_t;
endpackage
`default_nettype wire

// file: hw/evstk_addr_chk.sv
// evstk_addr_chk.sv - protected-mode address check and translation
`default_nettype none
module evstk_addr_chk #(
  parameter int AW = 32
) (
  input  wire logic [AW-1:0] prot_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [AW-1:0] base_in,
  input  wire logic [AW-1:0] limit_in,
  output logic      [AW-1:0] phys_out,
  output logic               fault_out
);
  if (AW != 32) begin : g_aw_chk
    $error("evstk_addr_chk supports 32-bit addresses only");
  end
  // flat addresses pass unchanged outside protected mode
  always_comb begin
    if (prot_in[0]) begin
      phys_out  = base_in + addr_in;
      fault_out = (addr_in > limit_in);
    end else begin
      phys_out  = addr_in;
      fault_out = 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// testbench.sv - self-checking bench for the evaluation stack datapath
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////////
  // clock, reset and stimulus
  logic                 clk_sys;    // core clock
  logic                 rst_n;      // active-low reset
  evstk_pkg::evstk_cmd_t cmd;       // instruction port
  logic                 prot;       // protected mode
  logic [31:0]          base;       // translation base
  logic [31:0]          limit;      // highest legal address
  logic                 trap_en;    // per-process trap select
  logic                 err_clr;    // error flag clear
  // observed outputs
  logic [31:0]          top, sec, thd, iptr, wptr, opnd, mem_addr;
  logic [63:0]          ftop, fsec, fthd, mem_wdata;
  logic                 mem_vld, mem_wr, trap, proc_err, glob_err;
  // bookkeeping
  int                   bad_count;  // mismatches seen
  int                   n_compared; // comparisons made
  logic [31:0]          ip_e;       // expected instruction pointer
  ////////////////////////////////////////////////////////////////////////////////
  evstk_core u_evstk_core (
    .CLK_SYS_IN(clk_sys), .RST_N_IN(rst_n), .CMD_IN(cmd), .PROT_IN(prot),
    .MMU_BASE_IN(base), .MMU_LIMIT_IN(limit), .TRAP_EN_IN(trap_en), .ERR_CLR_IN(err_clr),
    .TOP_OUT(top), .SEC_OUT(sec), .THD_OUT(thd), .FTOP_OUT(ftop), .FSEC_OUT(fsec),
    .FTHD_OUT(fthd), .IPTR_OUT(iptr), .WPTR_OUT(wptr), .OPND_OUT(opnd),
    .MEM_VLD_OUT(mem_vld), .MEM_WR_OUT(mem_wr), .MEM_ADDR_OUT(mem_addr),
    .MEM_WDATA_OUT(mem_wdata), .TRAP_OUT(trap), .PROC_ERR_OUT(proc_err),
    .GLOB_ERR_OUT(glob_err)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // free-running core clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // compare one value, four-state exact
  task automatic cmp(input logic [63:0] g, input logic [63:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // integer stack and instruction pointer
  task automatic cmp_stk(input logic [31:0] t, input logic [31:0] s, input logic [31:0] h);
    cmp(top, t, "top");
    cmp(sec, s, "second");
    cmp(thd, h, "third");
    cmp(iptr, ip_e, "iptr");
  endtask
  // float stack
  task automatic cmp_flt(input logic [63:0] t, input logic [63:0] s, input logic [63:0] h);
    cmp(ftop, t, "ftop");
    cmp(fsec, s, "fsec");
    cmp(fthd, h, "fthd");
  endtask
  // memory request
  task automatic cmp_mem(input logic v, input logic w, input logic [31:0] a,
                         input logic [63:0] d);
    cmp(mem_vld, v, "mem valid");
    if (v === 1'b1) begin
      cmp(mem_wr, w, "mem write");
      cmp(mem_addr, a, "mem addr");
      if (w) cmp(mem_wdata, d, "mem data");
    end
  endtask
  // one instruction; caller sits just after an edge, answer visible on return
  task automatic step(input evstk_pkg::evstk_op_t op, input logic [31:0] d,
                      input logic [63:0] fd, input logic dbl, input logic ok);
    cmd = '{vld: 1'b1, op: op, dbl: dbl, data: d, fdata: fd};
    @(posedge clk_sys);
    #1;
    if (ok) ip_e++;
  endtask
  // one empty cycle, ends any stream of instructions
  task automatic idle();
    cmd.vld = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  // verdict and end of run
  task automatic wrap_up();
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // back-to-back loads fill all three entries
  task automatic s_push();
    step(evstk_pkg::EVSTK_LDC, 32'h11, 64'h0, 1'b0, 1'b1);
    step(evstk_pkg::EVSTK_LDC, 32'h22, 64'h0, 1'b0, 1'b1);
    step(evstk_pkg::EVSTK_LDC, 32'h33, 64'h0, 1'b0, 1'b1);
    step(evstk_pkg::EVSTK_LDC, 32'h44, 64'h0, 1'b0, 1'b1);
    cmp_stk(32'h44, 32'h33, 32'h22);
    cmp(opnd, 64'h0, "operand");
  endtask
  // add, then byte and half loads zero-extend
  task automatic s_arith();
    step(evstk_pkg::EVSTK_ADD, 32'h0, 64'h0, 1'b0, 1'b1);
    cmp_stk(32'h77, 32'h22, 32'h22);
    step(evstk_pkg::EVSTK_LDB, 32'hCAFE_12AB, 64'h0, 1'b0, 1'b1);
    cmp_stk(32'hAB, 32'h77, 32'h22);
    step(evstk_pkg::EVSTK_LDH, 32'hCAFE_12AB, 64'h0, 1'b0, 1'b1);
    cmp_stk(32'h12AB, 32'hAB, 32'h77);
  endtask
  // prefixes build an address, byte store pops
  task automatic s_store();
    step(evstk_pkg::EVSTK_PFX, 32'h1, 64'h0, 1'b0, 1'b1);
    cmp(opnd, 64'h10, "operand");
    step(evstk_pkg::EVSTK_PFX, 32'h2, 64'h0, 1'b0, 1'b1);
    cmp(opnd, 64'h120, "operand");
    step(evstk_pkg::EVSTK_STB, 32'h0, 64'h0, 1'b0, 1'b1);
    cmp_mem(1'b1, 1'b1, 32'h120, 64'hAB);
    cmp_stk(32'hAB, 32'h77, 32'h77);
    cmp(opnd, 64'h0, "operand");
    // half-word store; a no-op in between must keep the operand
    step(evstk_pkg::EVSTK_LDC, 32'h0001_2345, 64'h0, 1'b0, 1'b1);
    step(evstk_pkg::EVSTK_PFX, 32'h3, 64'h0, 1'b0, 1'b1);
    step(evstk_pkg::EVSTK_NOP, 32'h0, 64'h0, 1'b0, 1'b1);
    cmp(opnd, 64'h30, "operand");
    step(evstk_pkg::EVSTK_STH, 32'h0, 64'h0, 1'b0, 1'b1);
    cmp_mem(1'b1, 1'b1, 32'h30, 64'h2345);
    cmp_stk(32'hAB, 32'h77, 32'h77);
    idle();
    cmp_mem(1'b0, 1'b0, 32'h0, 64'h0);
  endtask
  // float loads and store addressed from the integer stack
  task automatic s_float();
    step(evstk_pkg::EVSTK_FLD, 32'h0, 64'h0123_4567_89AB_CDEF, 1'b1, 1'b1);
    cmp_mem(1'b1, 1'b0, 32'hAB, 64'h0);
    cmp_flt(64'h0123_4567_89AB_CDEF, 64'h0, 64'h0);
    cmp_stk(32'h77, 32'h77, 32'h77);
    step(evstk_pkg::EVSTK_LDC, 32'h100, 64'h0, 1'b0, 1'b1);
    step(evstk_pkg::EVSTK_FLD, 32'h0, 64'hFFFF_FFFF_1111_2222, 1'b0, 1'b1);
    cmp_flt(64'h1111_2222, 64'h0123_4567_89AB_CDEF, 64'h0);
    step(evstk_pkg::EVSTK_LDC, 32'h200, 64'h0, 1'b0, 1'b1);
    step(evstk_pkg::EVSTK_FST, 32'h0, 64'h0, 1'b0, 1'b1);
    cmp_mem(1'b1, 1'b1, 32'h200, 64'h1111_2222);
    cmp_flt(64'h0123_4567_89AB_CDEF, 64'h0, 64'h0);
    step(evstk_pkg::EVSTK_LDC, 32'h4000, 64'h0, 1'b0, 1'b1);
    step(evstk_pkg::EVSTK_SWP, 32'h0, 64'h0, 1'b0, 1'b1);
    cmp(wptr, 64'h4000, "workspace");
    cmp_stk(32'h77, 32'h77, 32'h77);
    idle();
  endtask
  // protected mode: translation, faults, privileged op, both flags
  task automatic s_prot();
    prot = 1'b1;
    step(evstk_pkg::EVSTK_LDC, 32'h800, 64'h0, 1'b0, 1'b1);
    step(evstk_pkg::EVSTK_FLD, 32'h0, 64'h5, 1'b1, 1'b1);
    cmp_mem(1'b1, 1'b0, 32'h1000_0800, 64'h0);
    step(evstk_pkg::EVSTK_PFX, 32'h1, 64'h0, 1'b0, 1'b1);
    step(evstk_pkg::EVSTK_PFX, 32'h1, 64'h0, 1'b0, 1'b1);
    step(evstk_pkg::EVSTK_PFX, 32'h1, 64'h0, 1'b0, 1'b1);
    step(evstk_pkg::EVSTK_ST, 32'h0, 64'h0, 1'b0, 1'b0);
    cmp(trap, 64'h1, "trap");
    cmp_mem(1'b0, 1'b0, 32'h0, 64'h0);
    cmp_stk(32'h77, 32'h77, 32'h77);
    cmp({proc_err, glob_err}, 64'h2, "flags");
    trap_en = 1'b0;
    step(evstk_pkg::EVSTK_SWP, 32'h0, 64'h0, 1'b0, 1'b0);
    cmp(trap, 64'h1, "trap");
    cmp(wptr, 64'h4000, "workspace");
    cmp({proc_err, glob_err}, 64'h3, "flags");
    err_clr = 1'b1;
    idle();
    cmp(trap, 64'h0, "trap");
    err_clr = 1'b0;
    idle();
    cmp({proc_err, glob_err}, 64'h0, "flags");
    // trap in the clearing cycle: the set must win
    err_clr = 1'b1;
    step(evstk_pkg::EVSTK_SWP, 32'h0, 64'h0, 1'b0, 1'b0);
    cmp({proc_err, glob_err}, 64'h1, "flags");
    err_clr = 1'b0;
    cmp(iptr, ip_e, "iptr");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    bad_count = 0;
    n_compared = 0;
    ip_e = 32'h0;
    rst_n = 1'b0;
    cmd = '0;
    prot = 1'b0;
    base = 32'h1000_0000;
    limit = 32'h0000_0FFF;
    trap_en = 1'b1;
    err_clr = 1'b0;
    repeat (12) @(posedge clk_sys);
    #1;
    cmp_stk(32'h0, 32'h0, 32'h0);
    cmp_flt(64'h0, 64'h0, 64'h0);
    cmp({wptr, opnd}, 64'h0, "pointers in reset");
    cmp({mem_vld, mem_wr, trap, proc_err, glob_err}, 64'h0, "strobes in reset");
    rst_n = 1'b1;
    s_push();
    s_arith();
    s_store();
    s_float();
    s_prot();
    wrap_up();
  end
  // watchdog: the whole run needs well under a hundred cycles
  initial begin
    #(5000 * 40);
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
